// ### uart_mode_pkg.sv
// constants and types shared by both ends of the mode-controlled serial link
// Operation
// - device transmit gated by cts, rts reports room
// - four-wire with flow control or two-wire data only
// - host holds device cts low in two-wire
// - default 115200 baud, 8N1, flow control on
// - dsr and dtr carry module state, not handshake
// - dsr assertion runs the selected mode action
`default_nettype none
package uart_mode_pkg;
  // ****************************************************************
  // line timing
  // ****************************************************************
  localparam int unsigned CLK_HZ    = 200_000_000;
  localparam int unsigned BAUD      = 115_200;
  localparam int unsigned BIT_CYC   = (CLK_HZ + BAUD / 2) / BAUD;
  localparam logic [10:0] BIT_CNT   = 11'(BIT_CYC - 1);
  localparam logic [10:0] HALF_CNT  = 11'(BIT_CYC / 2 - 1);
  localparam logic [2:0]  LAST_BIT  = 3'h7; // 8 data bits, no parity, 1 stop
  // ****************************************************************
  // receive buffer
  // ****************************************************************
  localparam int unsigned FIFO_W    = 8;
  localparam int unsigned FIFO_D    = 8;
  // two slots of slack: the far end may already be sending a byte
  localparam logic [3:0]  RTS_HIGH  = 4'h6;
  // ****************************************************************
  // dsr actions and reset state
  // ****************************************************************
  typedef enum logic [1:0] {
    ACT_CMD   = 2'h0,
    ACT_DISC  = 2'h1,
    ACT_UART  = 2'h2,
    ACT_SLEEP = 2'h3
  } dsr_act_e;
  localparam logic RST_UART_EN  = 1'h1;
  localparam logic RST_CONNECT  = 1'h1;
  // ****************************************************************
  // host register map
  // ****************************************************************
  localparam int unsigned ADDR_W    = 8;
  localparam logic [7:0]  OFF_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_STAT  = 8'h04;
  localparam logic [7:0]  OFF_TXD   = 8'h08;
  localparam logic [7:0]  OFF_RXD   = 8'h0c;
  localparam int unsigned CTRL_FOUR = 0;
  localparam int unsigned CTRL_DSR  = 1;
  localparam logic [1:0]  RST_CTRL  = 2'h1;
  localparam int unsigned STAT_TXF  = 0;
  localparam int unsigned STAT_RXV  = 1;
  localparam int unsigned STAT_DTR  = 2;
  localparam int unsigned STAT_RTS  = 3;
  localparam int unsigned STAT_OVR  = 4;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // ****************************************************************
  // state machines
  // ****************************************************************
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_START = 4'b0010,
    S_DATA  = 4'b0100,
    S_STOP  = 4'b1000
  } ser_state_e;
endpackage
`default_nettype wire

// ### uart_link_if.sv
// wires between the module end and the host end, named from the module's view
`default_nettype none
interface uart_link_if;
  logic txd;
  logic rxd;
  logic cts_n;
  logic rts_n;
  logic dsr_n;
  logic dtr_n;
  modport dev  (output txd, rts_n, dtr_n, input rxd, cts_n, dsr_n);
  modport host (input txd, rts_n, dtr_n, output rxd, cts_n, dsr_n);
endinterface
`default_nettype wire

// ### uart_mode_dev.sv
// module end: serial core, receive fifo and dsr-driven mode control
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`default_nettype none
// ****************************************************************
// serial transmitter
// ****************************************************************
module uart_tx import uart_mode_pkg::*; (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // byte in
  input  wire logic       enable,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  // line
  output logic            txd
);
  ser_state_e  st_ff;
  logic [10:0] cnt_ff;
  logic [2:0]  bit_ff;
  logic [7:0]  shf_ff;
  logic        txd_ff;
  logic        rdy_ff;
  wire         tick = (cnt_ff == 11'h0);
  wire         take = in_valid & rdy_ff;
  assign in_ready = rdy_ff;
  assign txd      = txd_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff  <= S_IDLE;
      cnt_ff <= 11'h0;
      bit_ff <= 3'h0;
      shf_ff <= 8'h0;
      txd_ff <= 1'b1;
      rdy_ff <= 1'b0;
    end else begin
      if (st_ff != S_IDLE) cnt_ff <= tick ? BIT_CNT : cnt_ff - 11'h1;
      unique case (st_ff)
        S_IDLE: begin
          rdy_ff <= enable & ~take;
          if (take) begin
            shf_ff <= in_data;
            txd_ff <= 1'b0;
            cnt_ff <= BIT_CNT;
            bit_ff <= 3'h0;
            st_ff  <= S_START;
          end
        end
        S_START: if (tick) begin
          txd_ff <= shf_ff[0];
          shf_ff <= {1'b0, shf_ff[7:1]};
          st_ff  <= S_DATA;
        end
        S_DATA: if (tick) begin
          txd_ff <= (bit_ff == LAST_BIT) ? 1'b1 : shf_ff[0];
          shf_ff <= {1'b0, shf_ff[7:1]};
          bit_ff <= bit_ff + 3'h1;
          if (bit_ff == LAST_BIT) st_ff <= S_STOP;
        end
        S_STOP: if (tick) st_ff <= S_IDLE;
      endcase
    end
  end
endmodule // uart_tx

// ****************************************************************
// serial receiver
// ****************************************************************
module uart_rx import uart_mode_pkg::*; (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // line
  input  wire logic       enable,
  input  wire logic       rxd,
  // byte out
  output logic            out_valid,
  output logic [7:0]      out_data
);
  ser_state_e  st_ff;
  logic [10:0] cnt_ff;
  logic [2:0]  bit_ff;
  logic [7:0]  shf_ff;
  logic        vld_ff;
  wire         tick = (cnt_ff == 11'h0);
  assign out_valid = vld_ff;
  assign out_data  = shf_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff  <= S_IDLE;
      cnt_ff <= 11'h0;
      bit_ff <= 3'h0;
      shf_ff <= 8'h0;
      vld_ff <= 1'b0;
    end else begin
      vld_ff <= 1'b0;
      if (st_ff != S_IDLE) cnt_ff <= tick ? BIT_CNT : cnt_ff - 11'h1;
      unique case (st_ff)
        S_IDLE: if (enable && !rxd) begin
          cnt_ff <= HALF_CNT;
          st_ff  <= S_START;
        end
        // a start bit gone high at mid-bit was a glitch
        S_START: if (tick) begin
          bit_ff <= 3'h0;
          st_ff  <= rxd ? S_IDLE : S_DATA;
        end
        S_DATA: if (tick) begin
          shf_ff <= {rxd, shf_ff[7:1]};
          bit_ff <= bit_ff + 3'h1;
          if (bit_ff == LAST_BIT) st_ff <= S_STOP;
        end
        // bad stop bit: frame dropped
        S_STOP: if (tick) begin
          vld_ff <= rxd;
          st_ff  <= S_IDLE;
        end
      endcase
    end
  end
endmodule // uart_rx

// ****************************************************************
// receive fifo
// ****************************************************************
module sync_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // fill side
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  // drain side
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        count
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0]   cnt_ff;
  logic          ne_ff;
  logic          nf_ff;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;
  wire [AW:0]    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  // flags held in flops so the stream side sees registered valid and ready
  assign in_ready  = nf_ff;
  assign out_valid = ne_ff;
  assign out_data  = mem[rd_ff];
  assign count     = cnt_ff;
  always_ff @(posedge aclk) begin
    if (push) mem[wr_ff] <= in_data;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      ne_ff  <= 1'b0;
      nf_ff  <= 1'b1;
    end else begin
      if (push) wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + AW'(1);
      if (pop) rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + AW'(1);
      cnt_ff <= nxt_cnt;
      ne_ff  <= (nxt_cnt != '0);
      nf_ff  <= (nxt_cnt != (AW+1)'(D));
    end
  end
endmodule // sync_fifo

// ****************************************************************
// module end top
// ****************************************************************
module uart_mode_dev import uart_mode_pkg::*; (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // link
  uart_link_if.dev        link,
  // configuration
  input  wire logic       four_wire,
  input  wire logic [1:0] dsr_action,
  input  wire logic       cmd_done,
  // transmit stream
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // receive stream
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_overrun,
  // module state
  output logic            cmd_mode,
  output logic            connectable,
  output logic            disconnect,
  output logic            uart_en,
  output logic            sleep
);
  logic       dsr_q_ff;
  logic       cmd_ff;
  logic       conn_ff;
  logic       disc_ff;
  logic       en_ff;
  logic       sleep_ff;
  logic       rts_n_ff;
  logic       dtr_n_ff;
  logic       ovr_ff;
  logic       rxb_valid;
  logic [7:0] rxb_data;
  logic       fifo_ready;
  logic [3:0] fifo_cnt;
  wire        dsr_hit = dsr_q_ff & ~link.dsr_n;
  wire        active  = en_ff & ~sleep_ff;
  wire        tx_gate = active & (~four_wire | ~link.cts_n);
  wire        nxt_cmd = (dsr_hit & (dsr_action == ACT_CMD)) | (cmd_ff & ~cmd_done);
  wire        nxt_rts = four_wire ? (~active | (fifo_cnt >= RTS_HIGH)) : 1'b0;
  assign cmd_mode    = cmd_ff;
  assign connectable = conn_ff;
  assign disconnect  = disc_ff;
  assign uart_en     = en_ff;
  assign sleep       = sleep_ff;
  assign rx_overrun  = ovr_ff;
  assign link.rts_n  = rts_n_ff;
  assign link.dtr_n  = dtr_n_ff;

  uart_tx u_tx (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (tx_gate),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .in_data  (tx_data),
    .txd      (link.txd)
  );
  uart_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (active),
    .rxd       (link.rxd),
    .out_valid (rxb_valid),
    .out_data  (rxb_data)
  );
  sync_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rxb_valid),
    .in_ready  (fifo_ready),
    .in_data   (rxb_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .count     (fifo_cnt)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsr_q_ff <= 1'b1;
      cmd_ff   <= 1'b0;
      conn_ff  <= RST_CONNECT;
      disc_ff  <= 1'b0;
      en_ff    <= RST_UART_EN;
      sleep_ff <= 1'b0;
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      ovr_ff   <= 1'b0;
    end else begin
      dsr_q_ff <= link.dsr_n;
      cmd_ff   <= nxt_cmd;
      disc_ff  <= dsr_hit & (dsr_action == ACT_DISC);
      if (dsr_hit) begin
        unique case (dsr_action)
          ACT_CMD:   ;
          ACT_DISC:  conn_ff  <= ~conn_ff;
          ACT_UART:  en_ff    <= ~en_ff;
          ACT_SLEEP: sleep_ff <= ~sleep_ff;
        endcase
      end
      rts_n_ff <= nxt_rts;
      // dtr low while the port is enabled and awake
      dtr_n_ff <= ~(en_ff & ~sleep_ff);
      ovr_ff   <= rxb_valid & ~fifo_ready;
    end
  end
endmodule // uart_mode_dev
`default_nettype wire

// ### uart_mode_host.sv
// host end: axi4-lite register slave driving the serial link and dsr
`default_nettype none
module uart_mode_host import uart_mode_pkg::*; (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // link
  uart_link_if.host              link,
  // axi4-lite write
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi4-lite read
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp
);
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  logic [1:0]        ctrl_ff;
  logic              aw_h_ff;
  logic              w_h_ff;
  logic [ADDR_W-1:0] wa_ff;
  logic [31:0]       wd_ff;
  logic [3:0]        ws_ff;
  logic              awr_ff;
  logic              wr_ff;
  logic              bv_ff;
  logic [1:0]        br_ff;
  logic              arr_ff;
  logic              rv_ff;
  logic [31:0]       rd_ff;
  logic [1:0]        rr_ff;
  logic [7:0]        txb_ff;
  logic              txv_ff;
  logic [7:0]        rxb_ff;
  logic              rxv_ff;
  logic              ovr_ff;
  logic              cts_n_ff;
  logic              dsr_n_ff;
  logic              tx_rdy;
  logic              rx_v;
  logic [7:0]        rx_d;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire        aw_take  = awvalid & awr_ff;
  wire        w_take   = wvalid & wr_ff;
  wire        do_wr    = aw_h_ff & w_h_ff & ~bv_ff;
  wire        aw_nxt   = ~do_wr & (aw_h_ff | aw_take);
  wire        w_nxt    = ~do_wr & (w_h_ff | w_take);
  wire        bv_nxt   = do_wr | (bv_ff & ~bready);
  wire        ar_take  = arvalid & arr_ff;
  wire        rv_nxt   = ar_take | (rv_ff & ~rready);
  wire        wr_ctrl  = do_wr & hit(wa_ff, OFF_CTRL) & ws_ff[0];
  wire        wr_tx    = do_wr & hit(wa_ff, OFF_TXD) & ws_ff[0] & ~txv_ff;
  wire        wr_bad   = do_wr & ~hit(wa_ff, OFF_CTRL) & ~hit(wa_ff, OFF_TXD);
  wire        wr_full  = do_wr & hit(wa_ff, OFF_TXD) & txv_ff;
  wire        rd_ctrl  = hit(araddr, OFF_CTRL);
  wire        rd_stat  = hit(araddr, OFF_STAT);
  wire        rd_rx    = hit(araddr, OFF_RXD);
  wire        rd_ok    = rd_ctrl | rd_stat | rd_rx;
  wire        pop      = ar_take & rd_rx & rxv_ff;
  wire        stat_clr = ar_take & rd_stat;
  wire        four     = ctrl_ff[CTRL_FOUR];
  wire [31:0] stat_w   = {27'h0, ovr_ff, ~link.rts_n, ~link.dtr_n, rxv_ff, txv_ff};
  wire [31:0] rd_mux   = rd_ctrl ? {30'h0, ctrl_ff} :
                         rd_stat ? stat_w :
                         rd_rx   ? {24'h0, rxb_ff} : 32'h0;
  wire        tx_gate  = ~four | ~link.rts_n;
  wire        tx_take  = txv_ff & tx_rdy;
  assign awready    = awr_ff;
  assign wready     = wr_ff;
  assign bvalid     = bv_ff;
  assign bresp      = br_ff;
  assign arready    = arr_ff;
  assign rvalid     = rv_ff;
  assign rdata      = rd_ff;
  assign rresp      = rr_ff;
  assign link.cts_n = cts_n_ff;
  assign link.dsr_n = dsr_n_ff;

  uart_tx u_tx (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (tx_gate),
    .in_valid (txv_ff),
    .in_ready (tx_rdy),
    .in_data  (txb_ff),
    .txd      (link.rxd)
  );
  uart_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (1'b1),
    .rxd       (link.txd),
    .out_valid (rx_v),
    .out_data  (rx_d)
  );

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_ff <= 1'b0;
      w_h_ff  <= 1'b0;
      awr_ff  <= 1'b0;
      wr_ff   <= 1'b0;
      bv_ff   <= 1'b0;
      br_ff   <= RESP_OK;
      arr_ff  <= 1'b0;
      rv_ff   <= 1'b0;
      rr_ff   <= RESP_OK;
      rd_ff   <= 32'h0;
      wa_ff   <= '0;
      wd_ff   <= 32'h0;
      ws_ff   <= 4'h0;
    end else begin
      aw_h_ff <= aw_nxt;
      w_h_ff  <= w_nxt;
      awr_ff  <= ~aw_nxt & ~bv_nxt;
      wr_ff   <= ~w_nxt & ~bv_nxt;
      bv_ff   <= bv_nxt;
      arr_ff  <= ~rv_nxt;
      rv_ff   <= rv_nxt;
      if (aw_take) wa_ff <= awaddr;
      if (w_take) begin
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (do_wr) br_ff <= (wr_bad | wr_full) ? RESP_ERR : RESP_OK;
      if (ar_take) begin
        rd_ff <= rd_mux;
        rr_ff <= rd_ok ? RESP_OK : RESP_ERR;
      end
    end
  end

  // ****************************************************************
  // link side state
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff  <= RST_CTRL;
      txb_ff   <= 8'h0;
      txv_ff   <= 1'b0;
      rxb_ff   <= 8'h0;
      rxv_ff   <= 1'b0;
      ovr_ff   <= 1'b0;
      cts_n_ff <= 1'b1;
      dsr_n_ff <= 1'b1;
    end else begin
      if (wr_ctrl) ctrl_ff <= wd_ff[1:0];
      if (wr_tx) txb_ff <= wd_ff[7:0];
      txv_ff <= wr_tx | (txv_ff & ~tx_take);
      if (rx_v) rxb_ff <= rx_d;
      rxv_ff <= rx_v | (rxv_ff & ~pop);
      // a new overrun beats the clearing status read
      ovr_ff <= (rx_v & rxv_ff & ~pop) | (ovr_ff & ~stat_clr);
      // one byte of room: stop the module once it is taken
      cts_n_ff <= four ? (rxv_ff | rx_v) : 1'b0;
      dsr_n_ff <= ~ctrl_ff[CTRL_DSR];
    end
  end
endmodule // uart_mode_host
`default_nettype wire

// ### uart_link_monitor.sv
// link checker: framing and flow-control relations on the serial wires
`default_nettype none
module uart_link_monitor import uart_mode_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link wires
  input wire logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic dsr_n,
  input wire logic dtr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned FR = 10 * BIT_CYC;
  logic [14:0] tc_ff;
  logic [14:0] rc_ff;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // frame position, 1 at the edge after a start edge
  // ****
  always_ff @(posedge aclk) begin
    if (!aresetn) tc_ff <= '0;
    else if (tc_ff == 15'(FR - 1)) tc_ff <= '0;
    else if (tc_ff != '0 || $fell(txd)) tc_ff <= tc_ff + 15'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) rc_ff <= '0;
    else if (rc_ff == 15'(FR - 1)) rc_ff <= '0;
    else if (rc_ff != '0 || $fell(rxd)) rc_ff <= rc_ff + 15'h1;
  end
  // ****
  // assertions
  // ****
  line_idle_a: assert property ($rose(aresetn) |-> txd && rxd)
    else $error("line not idle after reset");
  link_up_a: assert property ($rose(aresetn) |-> rts_n && dtr_n ##1 !dtr_n)
    else $error("dtr not asserted after reset");
  tx_bit_a: assert property (tc_ff != 0 && tc_ff % BIT_CYC != 0 |-> $stable(txd))
    else $error("txd moved inside a bit");
  tx_stop_a: assert property (tc_ff >= 9 * BIT_CYC |-> txd)
    else $error("txd stop bit low");
  rx_bit_a: assert property (rc_ff != 0 && rc_ff % BIT_CYC != 0 |-> $stable(rxd))
    else $error("rxd moved inside a bit");
  rx_stop_a: assert property (rc_ff >= 9 * BIT_CYC |-> rxd)
    else $error("rxd stop bit low");
  // cts is looked at in idle only, so allow a short lag
  tx_gate_a: assert property (tc_ff == 0 && $fell(txd) |->
    !$past(cts_n) || !$past(cts_n, 2) || !$past(cts_n, 3))
    else $error("module sent while cts high");
  rx_gate_a: assert property (rc_ff == 0 && $fell(rxd) |->
    !$past(rts_n) || !$past(rts_n, 2) || !$past(rts_n, 3))
    else $error("host sent while rts high");
  cover property (tc_ff == 15'(FR - 1));
  cover property (rc_ff == 15'(FR - 1));
  cover property ($fell(dsr_n));
endmodule // uart_link_monitor
`default_nettype wire

// ### test_uart_with_mode_control_lines.sv
// self-checking bench: register end driving the module end over the link
`default_nettype none
module test_uart_with_mode_control_lines import uart_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and instances
  // ****
  logic aclk = 1'b0, aresetn = 1'b0, four_wire = 1'b1, cmd_done = 1'b0;
  logic [1:0] dsr_action = 2'h0;
  logic tx_valid = 1'b0, rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h0;
  logic tx_ready, rx_valid, cmd_mode, connectable, disconnect, uart_en, sleep, rx_overrun;
  logic [7:0] rx_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0, n_tests = 0, disc_cnt = 0, ovr_cnt = 0;
  uart_link_if link ();
  uart_mode_dev u_uart_mode_dev (.aclk, .aresetn, .link(link), .four_wire, .dsr_action,
    .cmd_done, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
    .rx_overrun, .cmd_mode, .connectable, .disconnect, .uart_en, .sleep);
  uart_mode_host u_uart_mode_host (.aclk, .aresetn, .link(link), .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  uart_link_monitor u_uart_link_monitor (.aclk, .aresetn, .txd(link.txd), .rxd(link.rxd),
    .cts_n(link.cts_n), .rts_n(link.rts_n), .dsr_n(link.dsr_n), .dtr_n(link.dtr_n));
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) if (disconnect === 1'b1) disc_cnt++;
  always @(posedge aclk) if (aresetn === 1'b1 && rx_overrun !== 1'b0) ovr_cnt++;
  // ****
  // tasks
  // ****
  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic late(input string what);
    error_cnt++;
    $display("ERROR t=%0t %s timed out", $time, what);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 1000);
    if (bvalid !== 1'b1) late("write");
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 1000);
    if (rvalid !== 1'b1) late("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(32'(r), 32'(er));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic host_get(input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    d = '0;
    for (int i = 0; i < 9000 && d[STAT_RXV] !== 1'b1; i++) axi_rd(OFF_STAT, d, r);
    if (d[STAT_RXV] !== 1'b1) late("host receive");
    rd_chk(OFF_RXD, {24'h0, e}, RESP_OK);
  endtask
  task automatic dev_put(input logic [7:0] b);
    int t;
    t = 0;
    @(posedge aclk);
    tx_valid <= 1'b1;
    tx_data <= b;
    do begin
      @(posedge aclk);
      t++;
    end while (tx_ready !== 1'b1 && t < 60000);
    if (tx_ready !== 1'b1) late("module send");
    tx_valid <= 1'b0;
  endtask
  task automatic dev_get(input logic [7:0] e);
    // let a pop from the previous call settle before looking at valid
    @(posedge aclk);
    for (int t = 0; t < 40000 && rx_valid !== 1'b1; t++) @(posedge aclk);
    if (rx_valid !== 1'b1) late("module receive");
    chk({24'h0, rx_data}, {24'h0, e});
    rx_ready <= 1'b1;
    @(posedge aclk);
    rx_ready <= 1'b0;
  endtask
  // samples the host line mid-bit: start, data lsb first, stop
  task automatic chk_wire(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int t = 0; t < 9000 && link.rxd !== 1'b0; t++) @(posedge aclk);
    if (link.rxd !== 1'b0) late("start bit");
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      chk({31'h0, link.rxd}, {31'h0, f[i]});
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (80000) @(posedge aclk);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    complete_run();
  end
  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] st;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({28'h0, cmd_mode, connectable, uart_en, sleep}, 32'h6);
    rd_chk(OFF_CTRL, 32'(RST_CTRL), RESP_OK);
    rd_chk(OFF_STAT, 32'h1 << STAT_DTR | 32'h1 << STAT_RTS, RESP_OK);
    rd_chk(8'h10, 32'h0, RESP_ERR);
    fork
      begin dev_put(8'h3c); dev_put(8'h96); end
      begin chk_wire(8'ha5); dev_get(8'ha5); dev_get(8'h77); end
      begin
        wr_chk(OFF_TXD, 32'ha5, RESP_OK);
        d = 32'h1;
        for (int i = 0; i < 99 && d[STAT_TXF] !== 1'b0; i++) axi_rd(OFF_STAT, d, r);
        wr_chk(OFF_TXD, 32'h77, RESP_OK);
        wr_chk(OFF_TXD, 32'h11, RESP_ERR);
      end
      begin
        // host still holds 0x3c, so the second module byte must wait
        repeat (12 * BIT_CYC) @(posedge aclk);
        chk({30'h0, link.cts_n, link.txd}, 32'h3);
        host_get(8'h3c);
        host_get(8'h96);
      end
    join
    four_wire <= 1'b0;
    wr_chk(OFF_CTRL, 32'h0, RESP_OK);
    repeat (4) @(posedge aclk);
    chk({30'h0, link.cts_n, link.rts_n}, 32'h0);
    fork
      dev_put(8'h42);
      dev_get(8'h81);
      begin wr_chk(OFF_TXD, 32'h81, RESP_OK); host_get(8'h42); end
    join
    st = 4'h6;
    for (int a = 0; a < 4; a++) begin
      for (int k = 0; k < 2; k++) begin
        dsr_action <= 2'(a);
        wr_chk(OFF_CTRL, 32'h2, RESP_OK);
        repeat (8) @(posedge aclk);
        st[3-a] = (a == 0) | !st[3-a];
        chk({28'h0, cmd_mode, connectable, uart_en, sleep}, {28'h0, st});
        axi_rd(OFF_STAT, d, r);
        chk(32'(d[STAT_DTR]), 32'(st[1] & !st[0]));
        if (a == 0) begin
          cmd_done <= 1'b1;
          @(posedge aclk);
          cmd_done <= 1'b0;
          st[3] = 1'b0;
        end
        wr_chk(OFF_CTRL, 32'h0, RESP_OK);
        repeat (4) @(posedge aclk);
      end
    end
    chk({28'h0, cmd_mode, connectable, uart_en, sleep}, {28'h0, st});
    chk(32'(disc_cnt), 32'h2);
    chk(32'(ovr_cnt), 32'h0);
    complete_run();
  end
endmodule // test_uart_with_mode_control_lines
`default_nettype wire
